/* common/dat_defines.vh */
`ifndef DAT_DEFINES_VH
`define DAT_DEFINES_VH
// ----------------------------------------
// Register map (byte offsets)
// ----------------------------------------
`define DAT_OFS_CONTROL_ONE 8'h20
`define DAT_OFS_STATUS 8'h21
`define DAT_OFS_TRACE_CTRL 8'h22
`define DAT_OFS_VIEW_REG 8'h27
`define DAT_OFS_WIN_LO 8'h28
`define DAT_OFS_WIN_HI 8'h2F
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define DAT_BIT_SESSION_ACTIVE 7
`define DAT_BIT_FORCED_FIRE 6
`define DAT_BIT_RESERVED5 5
`define DAT_BIT_BACKGROUND_HALT 4
`define DAT_BIT_FINAL_BRK 3
`define DAT_LOCK_MASK 8'h3C
`define DAT_VIEW_HI 1
`define DAT_VIEW_LO 0
`define DAT_CONTROL_RESET 8'h00
// ----------------------------------------
// Status and trace control fields
// ----------------------------------------
`define DAT_BIT_BUFFER_FULL 7
`define DAT_BIT_TRACE_SOURCE 6
`define DAT_TRACE_CTRL_MASK 8'h7F
`define DAT_TRACE_CTRL_RESET 8'h00
`define DAT_ALIGN_HI 1
`define DAT_ALIGN_LO 0
// ----------------------------------------
// Bank view codes, sequencer states and end alignment code
// ----------------------------------------
`define DAT_VIEW_A 2'h0
`define DAT_VIEW_B 2'h1
`define DAT_VIEW_C 2'h2
`define DAT_VIEW_D 2'h3
`define DAT_SSF_IDLE 3'h0
`define DAT_SSF_FIRST 3'h1
`define DAT_SSF_FINAL 3'h4
`define DAT_ALIGN_END 2'h0
`endif

/* hw/dat_sync.v */
module dat_sync (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Asynchronous input and filtered level
    input wire din,
    output reg dout
);
    reg s1;
    reg s2;
    reg s3;

    // ----------------------------------------
    // Three stages; change taken once last two agree
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                dout <= s3;
        end
    end
endmodule

/* hw/dat_bank_mux.v */
`include "dat_defines.vh"
module dat_bank_mux (
    // Selection
    input wire [1:0] bank_view_select,
    input wire [2:0] win_index,
    // Comparator banks, eight bytes each
    input wire [63:0] comp_a_bank,
    input wire [63:0] comp_b_bank,
    input wire [63:0] comp_c_bank,
    input wire [63:0] comp_d_bank,
    // Shared view register sources
    input wire [7:0] sequencer_control_one,
    input wire [7:0] sequencer_control_two,
    input wire [7:0] sequencer_control_three,
    input wire [7:0] match_flag_register,
    // Selected bytes
    output reg [7:0] win_byte,
    output reg [7:0] view_byte
);
    reg [63:0] bank;

    always @*
    begin
        case (bank_view_select)
            `DAT_VIEW_A: bank = comp_a_bank;
            `DAT_VIEW_B: bank = comp_b_bank;
            `DAT_VIEW_C: bank = comp_c_bank;
            default: bank = comp_d_bank;
        endcase
        win_byte = bank[{win_index, 3'h0} +: 8];
        case (bank_view_select)
            `DAT_VIEW_A: view_byte = sequencer_control_one;
            `DAT_VIEW_B: view_byte = sequencer_control_two;
            `DAT_VIEW_C: view_byte = sequencer_control_three;
            default: view_byte = match_flag_register;
        endcase
    end
endmodule

/* hw/dat_control.v */
`include "dat_defines.vh"
module dat_control (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Comparator banks and shared view sources
    input wire [63:0] comp_a_bank,
    input wire [63:0] comp_b_bank,
    input wire [63:0] comp_c_bank,
    input wire [63:0] comp_d_bank,
    input wire [7:0] sequencer_control_one,
    input wire [7:0] sequencer_control_two,
    input wire [7:0] sequencer_control_three,
    input wire [7:0] match_flag_register,
    // Sequencer and trace events, same clock
    input wire seq_final_reached,
    input wire [2:0] seq_state_next,
    input wire seq_state_load,
    input wire trace_started,
    input wire trace_complete,
    input wire buffer_full_set,
    // System status from pins
    input wire mcu_secure,
    input wire background_port_enable,
    input wire background_active,
    // Outputs to sequencer and trace logic
    output wire session_active,
    output wire [1:0] bank_view_select,
    output reg sequencer_arm_pulse,
    output reg forced_fire_pulse,
    output reg trace_enable,
    output reg [1:0] capture_alignment,
    // Breakpoint requests to the core
    output reg brk_halt_req,
    output reg brk_swi_req
);
    reg [7:0] control_one;
    reg [7:0] trace_ctrl;
    reg [2:0] sequencer_state_flags;
    reg capture_buffer_full;
    reg trace_running;
    reg next_active;
    reg [7:0] next_control;
    reg [7:0] next_rdata;
    wire secure_s;
    wire port_en_s;
    wire bg_active_s;
    wire [7:0] win_byte;
    wire [7:0] view_byte;
    wire wr_ctrl;
    wire arm_write;
    wire fire_write;
    wire fire_ok;
    wire brk_event;
    wire hw_disarm;
    wire tracing_on;
    wire arm_accept;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    dat_sync u_sync_secure (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(mcu_secure),
        .dout(secure_s)
    );
    dat_sync u_sync_port (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(background_port_enable),
        .dout(port_en_s)
    );
    dat_sync u_sync_active (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(background_active),
        .dout(bg_active_s)
    );

    // ----------------------------------------
    // Window and view selection
    // ----------------------------------------
    dat_bank_mux u_mux (
        .bank_view_select(bank_view_select),
        .win_index(reg_addr[2:0]),
        .comp_a_bank(comp_a_bank),
        .comp_b_bank(comp_b_bank),
        .comp_c_bank(comp_c_bank),
        .comp_d_bank(comp_d_bank),
        .sequencer_control_one(sequencer_control_one),
        .sequencer_control_two(sequencer_control_two),
        .sequencer_control_three(sequencer_control_three),
        .match_flag_register(match_flag_register),
        .win_byte(win_byte),
        .view_byte(view_byte)
    );

    // ----------------------------------------
    // Window address decode
    // ----------------------------------------
    function in_window;
        input [7:0] a;
        begin
            in_window = (a >= `DAT_OFS_WIN_LO) && (a <= `DAT_OFS_WIN_HI);
        end
    endfunction

    // ----------------------------------------
    // Control decode
    // ----------------------------------------
    assign session_active = control_one[`DAT_BIT_SESSION_ACTIVE];
    assign bank_view_select = control_one[`DAT_VIEW_HI:`DAT_VIEW_LO];
    assign wr_ctrl = reg_wr && (reg_addr == `DAT_OFS_CONTROL_ONE);
    assign arm_write = wr_ctrl && reg_wdata[`DAT_BIT_SESSION_ACTIVE];
    assign fire_write = wr_ctrl && reg_wdata[`DAT_BIT_FORCED_FIRE];

    // ----------------------------------------
    // Trace gating and forced fire acceptance
    // ----------------------------------------
    // Secure parts never trace
    assign tracing_on = trace_ctrl[`DAT_BIT_TRACE_SOURCE] && !secure_s;
    // Aligned-at-begin/mid traces already running ignore fire
    assign fire_ok = fire_write && session_active && !secure_s
        && !(trace_running && capture_alignment != `DAT_ALIGN_END);

    // ----------------------------------------
    // Breakpoint source and hardware disarm
    // ----------------------------------------
    // Breakpoint source: completed trace when tracing, else final state or forced fire
    assign brk_event = control_one[`DAT_BIT_FINAL_BRK] && session_active
        && (tracing_on ? trace_complete
        : (seq_final_reached || fire_ok));
    assign hw_disarm = session_active
        && ((tracing_on && trace_complete) || (!tracing_on && brk_event));
    // Arm only from disarmed; a same-cycle disarm wins
    assign arm_accept = arm_write && !session_active && !hw_disarm;

    // ----------------------------------------
    // Next control value
    // ----------------------------------------
    always @*
    begin
        next_control = control_one;
        next_active = session_active;
        if (wr_ctrl)
        begin
            next_active = reg_wdata[`DAT_BIT_SESSION_ACTIVE];
            next_control[`DAT_VIEW_HI:`DAT_VIEW_LO] = reg_wdata[`DAT_VIEW_HI:`DAT_VIEW_LO];
            // Lock judged on state before write, so disarming write keeps 5:2
            if (!session_active)
                next_control = (next_control & ~`DAT_LOCK_MASK) | (reg_wdata & `DAT_LOCK_MASK);
        end
        if (hw_disarm)
            next_active = 1'b0;
        next_control[`DAT_BIT_SESSION_ACTIVE] = next_active;
        next_control[`DAT_BIT_FORCED_FIRE] = 1'b0;
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (!rst_n)
            control_one <= `DAT_CONTROL_RESET;
        else
            control_one <= next_control;
    end

    // ----------------------------------------
    // Trace control and trace outputs
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            trace_ctrl <= `DAT_TRACE_CTRL_RESET;
            trace_enable <= 1'b0;
            capture_alignment <= `DAT_ALIGN_END;
        end
        else
        begin
            // Trace control writable only disarmed; secure blocks source
            if (reg_wr && reg_addr == `DAT_OFS_TRACE_CTRL && !session_active)
            begin
                trace_ctrl <= reg_wdata & `DAT_TRACE_CTRL_MASK;
                if (secure_s)
                    trace_ctrl[`DAT_BIT_TRACE_SOURCE] <= 1'b0;
            end
            trace_enable <= tracing_on;
            capture_alignment <= trace_ctrl[`DAT_ALIGN_HI:`DAT_ALIGN_LO];
        end
    end

    // ----------------------------------------
    // Running trace tracker
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (!rst_n)
            trace_running <= 1'b0;
        else if (arm_write && !hw_disarm)
            trace_running <= 1'b0;
        else if (trace_started && tracing_on)
            trace_running <= 1'b1;
        else if (trace_complete)
            trace_running <= 1'b0;
    end

    // ----------------------------------------
    // Sequencer arming and state flags
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sequencer_arm_pulse <= 1'b0;
            sequencer_state_flags <= `DAT_SSF_IDLE;
        end
        else
        begin
            // Arming enters state one; a same-cycle disarm wins
            sequencer_arm_pulse <= arm_accept;
            if (arm_accept)
                sequencer_state_flags <= `DAT_SSF_FIRST;
            else if (hw_disarm)
                sequencer_state_flags <= `DAT_SSF_IDLE;
            else if (seq_state_load && session_active)
                sequencer_state_flags <= seq_state_next;
        end
    end

    // ----------------------------------------
    // Capture buffer full flag
    // ----------------------------------------
    // Hardware fill beats the arm-write clear, so no fill is lost
    always @(posedge mclk)
    begin
        if (!rst_n)
            capture_buffer_full <= 1'b0;
        else if (buffer_full_set)
            capture_buffer_full <= 1'b1;
        else if (arm_write)
            capture_buffer_full <= 1'b0;
    end

    // ----------------------------------------
    // Forced fire pulse
    // ----------------------------------------
    // Without tracing and with bit 3 set the fire becomes a breakpoint instead
    always @(posedge mclk)
    begin
        if (!rst_n)
            forced_fire_pulse <= 1'b0;
        else
            forced_fire_pulse <= fire_ok && (tracing_on || !control_one[`DAT_BIT_FINAL_BRK]);
    end

    // ----------------------------------------
    // Breakpoint routing to the core
    // ----------------------------------------
    // Bit 5 is stored but drives nothing
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            brk_halt_req <= 1'b0;
            brk_swi_req <= 1'b0;
        end
        else if (control_one[`DAT_BIT_BACKGROUND_HALT])
        begin
            brk_halt_req <= brk_event && port_en_s;
            brk_swi_req <= brk_event && !port_en_s;
        end
        else
        begin
            brk_halt_req <= 1'b0;
            brk_swi_req <= brk_event && !bg_active_s;
        end
    end

    // ----------------------------------------
    // Read decode; unmapped addresses read zero
    // ----------------------------------------
    always @*
    begin
        next_rdata = 8'h00;
        if (reg_rd)
        begin
            if (reg_addr == `DAT_OFS_CONTROL_ONE)
                next_rdata = control_one;
            else if (reg_addr == `DAT_OFS_STATUS)
                next_rdata = {capture_buffer_full, 4'h0, sequencer_state_flags};
            else if (reg_addr == `DAT_OFS_TRACE_CTRL)
                next_rdata = trace_ctrl;
            else if (reg_addr == `DAT_OFS_VIEW_REG)
                next_rdata = view_byte;
            else if (in_window(reg_addr))
                next_rdata = win_byte;
        end
    end

    // ----------------------------------------
    // Read data register, held for one cycle only
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= next_rdata;
    end
endmodule

/* test/dat_core_model.sv */
module dat_core_model (
    // Clock and reset
    input logic mclk,
    input logic rst_n,
    // Breakpoint requests from the debug unit
    input logic brk_halt_req,
    input logic brk_swi_req,
    // Breakpoints taken so far
    output int n_halt,
    output int n_swi
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Core side: count every one-cycle request
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            n_halt <= 0;
            n_swi <= 0;
        end
        else
        begin
            if (brk_halt_req === 1'b1)
                n_halt <= n_halt + 1;
            if (brk_swi_req === 1'b1)
                n_swi <= n_swi + 1;
        end
    end
endmodule

/* test/dat_control_monitor.sv */
module dat_control_monitor (
    // Clock and reset
    input logic mclk,
    input logic rst_n,
    // Register port
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    // Window sources
    input logic [63:0] comp_a_bank,
    input logic [63:0] comp_b_bank,
    input logic [63:0] comp_c_bank,
    input logic [63:0] comp_d_bank,
    input logic [7:0] sequencer_control_one,
    input logic [7:0] sequencer_control_two,
    input logic [7:0] sequencer_control_three,
    input logic [7:0] match_flag_register,
    // Status and results
    input logic mcu_secure,
    input logic session_active,
    input logic [1:0] bank_view_select,
    input logic sequencer_arm_pulse,
    input logic forced_fire_pulse,
    input logic trace_enable,
    input logic brk_halt_req,
    input logic brk_swi_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] lock;
    logic [63:0] bank;
    logic [7:0] shifted;
    logic [7:0] view;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Shadow of bits 5:2, only loaded while disarmed
    // ----------------------------------------
    always @(posedge mclk)
    begin
        if (!rst_n)
            lock <= 4'h0;
        else if (reg_wr && reg_addr == 8'h20 && !session_active)
            lock <= reg_wdata[5:2];
    end
    assign bank = bank_view_select == 2'h0 ? comp_a_bank : bank_view_select == 2'h1 ? comp_b_bank :
        bank_view_select == 2'h2 ? comp_c_bank : comp_d_bank;
    assign shifted = 8'(bank >> {reg_addr[2:0], 3'h0});
    assign view = bank_view_select == 2'h0 ? sequencer_control_one : bank_view_select == 2'h1 ?
        sequencer_control_two : bank_view_select == 2'h2 ? sequencer_control_three : match_flag_register;
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_FIRE_READS_ZERO: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata[6] == 1'b0)
        else $error("fire bit read back as one");
    AST_LOCKED_BITS: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata[5:2] == $past(lock))
        else $error("bits 5:2 changed while armed");
    AST_VIEW_WRITE: assert property (reg_wr && reg_addr == 8'h20 |=> bank_view_select == $past(reg_wdata[1:0]))
        else $error("view select not written");
    AST_WINDOW: assert property (reg_rd && reg_addr[7:3] == 5'h05 |=> reg_rdata == $past(shifted))
        else $error("window byte wrong");
    AST_VIEW_REG: assert property (reg_rd && reg_addr == 8'h27 |=> reg_rdata == $past(view))
        else $error("shared view register wrong");
    AST_BREAK_DISARMS: assert property (brk_halt_req || brk_swi_req |-> !session_active)
        else $error("still armed after breakpoint");
    AST_HALT_NEEDS_BIT4: assert property (brk_halt_req |-> lock[2])
        else $error("halt request with bit 4 clear");
    AST_FIRE_CAUSE: assert property (forced_fire_pulse |-> $past(reg_wr) && $past(reg_addr) == 8'h20 && $past(reg_wdata[6]))
        else $error("fire pulse without fire write");
    AST_ARM_ENTERS: assert property (sequencer_arm_pulse |-> session_active)
        else $error("arm pulse while disarmed");
    AST_SECURE_QUIET: assert property (mcu_secure [*6] |-> !trace_enable && !forced_fire_pulse)
        else $error("tracing or fire while secured");
    COV_HALT: cover property (brk_halt_req);
    COV_SWI: cover property (brk_swi_req);
    COV_FIRE: cover property (forced_fire_pulse);
endmodule

/* test/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n, reg_wr, reg_rd, seq_final_reached, seq_state_load, trace_started, trace_complete;
    logic buffer_full_set, mcu_secure, background_port_enable, background_active;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] seq_state_next;
    logic [63:0] bk [4];
    logic [7:0] sc [4];
    logic [4:0] tab [4];
    wire session_active, sequencer_arm_pulse, forced_fire_pulse, trace_enable, brk_halt_req, brk_swi_req;
    wire [1:0] bank_view_select, capture_alignment;
    int n_halt, n_swi, eh, es, n_fire, n_mismatch, samples_checked;
    dat_control dat_control_inst (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .comp_a_bank(bk[0]), .comp_b_bank(bk[1]), .comp_c_bank(bk[2]), .comp_d_bank(bk[3]),
        .sequencer_control_one(sc[0]), .sequencer_control_two(sc[1]), .sequencer_control_three(sc[2]),
        .match_flag_register(sc[3]), .seq_final_reached, .seq_state_next, .seq_state_load, .trace_started,
        .trace_complete, .buffer_full_set, .mcu_secure, .background_port_enable, .background_active,
        .session_active, .bank_view_select, .sequencer_arm_pulse, .forced_fire_pulse, .trace_enable,
        .capture_alignment, .brk_halt_req, .brk_swi_req);
    dat_core_model dat_core_model_inst (.mclk, .rst_n, .brk_halt_req, .brk_swi_req, .n_halt, .n_swi);
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (forced_fire_pulse === 1'b1)
            n_fire++;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // Pulse one event input: 0 final state, 1 trace done, 2 buffer full, 3 trace start, 4 state load
    task pl(input int sel);
        @(posedge mclk);
        seq_final_reached <= sel == 0;
        trace_complete <= sel == 1;
        buffer_full_set <= sel == 2;
        trace_started <= sel == 3;
        seq_state_load <= sel == 4;
        @(posedge mclk);
        {seq_final_reached, trace_complete, buffer_full_set, trace_started, seq_state_load} <= 5'h0;
    endtask
    task brk(input int h, input int s);
        eh += h;
        es += s;
        repeat (3) @(posedge mclk);
        #1 chk(n_halt[7:0], eh[7:0]);
        chk(n_swi[7:0], es[7:0]);
    endtask
    // Pin inputs pass a synchroniser, so allow them to settle
    task pins(input logic p, input logic b, input logic s);
        @(posedge mclk);
        {background_port_enable, background_active, mcu_secure} <= {p, b, s};
        repeat (6) @(posedge mclk);
    endtask
    task t_lock;
        rd(8'h20, 8'h00);
        pl(2);
        rd(8'h21, 8'h80);
        wr(8'h20, 8'h7D);
        rd(8'h20, 8'h3D);
        wr(8'h20, 8'h9A);
        rd(8'h21, 8'h01);
        pl(4);
        rd(8'h21, 8'h04);
        wr(8'h20, 8'hA5);
        rd(8'h20, 8'h99);
        wr(8'h20, 8'h00);
        rd(8'h20, 8'h18);
        wr(8'h20, 8'h00);
        rd(8'h20, 8'h00);
    endtask
    task t_view;
        for (int v = 0; v < 4; v++)
        begin
            wr(8'h20, 8'(v));
            rd(8'h27, sc[v]);
            for (int k = 0; k < 8; k++)
                rd(8'h28 + 8'(k), bk[v][8 * k +: 8]);
        end
        rd(8'h3F, 8'h00);
    endtask
    task t_brk;
        for (int i = 0; i < 4; i++)
        begin
            pins(tab[i][3], tab[i][2], 1'b0);
            wr(8'h20, {3'h0, tab[i][4], 4'h8});
            wr(8'h20, {3'h4, tab[i][4], 4'h8});
            pl(0);
            brk(tab[i][1], tab[i][0]);
            if (tab[i][1:0] != 2'h0)
                chk({7'h0, session_active}, 8'h00);
            wr(8'h20, 8'h00);
        end
        pins(1'b0, 1'b0, 1'b0);
    endtask
    task t_race;
        wr(8'h20, 8'h88);
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_wr, seq_final_reached} <= {16'h2088, 2'h3};
        @(posedge mclk);
        {reg_wr, seq_final_reached} <= 2'h0;
        brk(0, 1);
        chk({7'h0, session_active}, 8'h00);
    endtask
    task t_fire;
        wr(8'h22, 8'h40);
        wr(8'h20, 8'h88);
        wr(8'h20, 8'hC8);
        brk(0, 0);
        chk(n_fire[7:0], 8'h01);
        chk({7'h0, session_active}, 8'h01);
        pl(1);
        brk(0, 1);
        wr(8'h22, 8'h41);
        wr(8'h20, 8'h88);
        pl(3);
        wr(8'h20, 8'hC8);
        chk(n_fire[7:0], 8'h01);
        chk({6'h0, capture_alignment}, 8'h01);
        pl(1);
        brk(0, 1);
        wr(8'h22, 8'h00);
        wr(8'h20, 8'h88);
        wr(8'h20, 8'hC8);
        brk(0, 1);
        chk(n_fire[7:0], 8'h01);
        pins(1'b0, 1'b0, 1'b1);
        wr(8'h22, 8'h40);
        repeat (2) @(posedge mclk);
        #1 chk({7'h0, trace_enable}, 8'h00);
        wr(8'h20, 8'h88);
        wr(8'h20, 8'hC8);
        brk(0, 0);
        chk({7'h0, session_active}, 8'h01);
        wr(8'h20, 8'h00);
    endtask
    task conclude;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        conclude();
    end
    initial
    begin
        {rst_n, reg_wr, reg_rd, seq_final_reached, seq_state_load, trace_started, trace_complete} = 7'h0;
        {buffer_full_set, mcu_secure, background_port_enable, background_active} = 4'h0;
        {reg_addr, reg_wdata, seq_state_next} = 19'h4;
        eh = 0;
        es = 0;
        n_fire = 0;
        n_mismatch = 0;
        samples_checked = 0;
        bk = '{64'hA7A6A5A4A3A2A1A0, 64'hB7B6B5B4B3B2B1B0, 64'hC7C6C5C4C3C2C1C0, 64'hD7D6D5D4D3D2D1D0};
        sc = '{8'h11, 8'h22, 8'h33, 8'h44};
        tab = '{5'h1A, 5'h11, 5'h01, 5'h0C};
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_lock();
        t_view();
        t_brk();
        t_race();
        t_fire();
        conclude();
    end
endmodule
bind dat_control dat_control_monitor dat_control_monitor_inst (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .comp_a_bank, .comp_b_bank, .comp_c_bank, .comp_d_bank, .sequencer_control_one,
    .sequencer_control_two, .sequencer_control_three, .match_flag_register, .mcu_secure, .session_active,
    .bank_view_select, .sequencer_arm_pulse, .forced_fire_pulse, .trace_enable, .brk_halt_req, .brk_swi_req);
